//--- pkg/wave_shaping_gain_cfg.svh
// Constants for the wave shaping and gain state register bank
`ifndef WAVE_SHAPING_GAIN_CFG_SVH
`define WAVE_SHAPING_GAIN_CFG_SVH

// Register indices and the byte address base of each register space
`define IDX_GAIN_STATE      8'h2E
`define IDX_WS_CONFIG_ONE   8'h2E
`define IDX_WS_CONFIG_TWO   8'h2F
`define SPACE_A_BASE        12'h000
`define SPACE_B_BASE        12'h100

// Field positions of configuration one
`define CFG1_CONT_BIT       3
`define CFG1_RX_ONLY_BIT    1
`define CFG1_ONOFF_BIT      0
// Field positions of configuration two
`define CFG2_SYM_BIT        5
`define CFG2_SINK_BIT       4
`define CFG2_FILT_MSB       3
`define CFG2_FILT_LSB       0

// Reset values and the gain cut saturation limit
`define CFG1_RESET          8'h00
`define CFG2_RESET          8'h00
`define GAIN_CUT_MAX        4'hF

`endif

//--- pkg/wave_shaping_gain_pkg.sv
// Types shared by the wave shaping and gain state register bank
`default_nettype none
package wave_shaping_gain_pkg;
  typedef logic [3:0]  gain_cut_t;
  typedef logic [11:0] apb_addr_t;
  typedef logic [31:0] apb_data_t;
  typedef enum logic [0:0] {
    BUS_IDLE   = 1'b0,
    BUS_ANSWER = 1'b1
  } bus_state_t;
endpackage
`default_nettype wire

//--- rtl/gain_cut_combiner.sv
// Combines programmed, squelch and AGC gain cut into one saturated total
`timescale 1ns/1ps
`default_nettype none
`include "wave_shaping_gain_cfg.svh"
module gain_cut_combiner (
  // Clock and reset
  input  wire logic                          i_clk,
  input  wire logic                          i_reset_n,
  // Gain cut contributions
  input  wire wave_shaping_gain_pkg::gain_cut_t i_setting,
  input  wire wave_shaping_gain_pkg::gain_cut_t i_squelch,
  input  wire wave_shaping_gain_pkg::gain_cut_t i_agc,
  // Combined total
  output var  wave_shaping_gain_pkg::gain_cut_t o_total
);
  import wave_shaping_gain_pkg::*;

  gain_cut_t next_total;

  // Saturating add keeps the code inside the setting field's range
  function automatic gain_cut_t sat_add(input gain_cut_t a, input gain_cut_t b);
    logic [4:0] sum;
    sum = {1'b0, a} + {1'b0, b};
    sat_add = sum[4] ? `GAIN_CUT_MAX : sum[3:0];
  endfunction

  // Total of all three contributions
  always_comb begin
    next_total = sat_add(sat_add(i_setting, i_squelch), i_agc);
  end

  // Snapshot register
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_total <= 4'h0;
    end else begin
      o_total <= next_total;
    end
  end
endmodule // gain_cut_combiner
`default_nettype wire

//--- rtl/wave_shaping_gain_regs.sv
// APB register bank for receive gain state and active wave shaping setup
`timescale 1ns/1ps
`default_nettype none
`include "wave_shaping_gain_cfg.svh"
module wave_shaping_gain_regs (
  // Clock and reset
  input  wire logic                              I_CLK,
  input  wire logic                              I_RESET_N,
  // APB slave
  input  wire logic                              I_PSEL,
  input  wire logic                              I_PENABLE,
  input  wire logic                              I_PWRITE,
  input  wire wave_shaping_gain_pkg::apb_addr_t  I_PADDR,
  input  wire wave_shaping_gain_pkg::apb_data_t  I_PWDATA,
  output var  wave_shaping_gain_pkg::apb_data_t  O_PRDATA,
  output logic                                   O_PREADY,
  output logic                                   O_PSLVERR,
  // Receive gain contributions, same clock domain
  input  wire wave_shaping_gain_pkg::gain_cut_t  I_AM_GAIN_SETTING_FIELD,
  input  wire wave_shaping_gain_pkg::gain_cut_t  I_PM_GAIN_SETTING_FIELD,
  input  wire wave_shaping_gain_pkg::gain_cut_t  I_AM_SQUELCH_CUT,
  input  wire wave_shaping_gain_pkg::gain_cut_t  I_PM_SQUELCH_CUT,
  input  wire wave_shaping_gain_pkg::gain_cut_t  I_AM_AGC_CUT,
  input  wire wave_shaping_gain_pkg::gain_cut_t  I_PM_AGC_CUT,
  // Transmit timing and mode, same clock domain
  input  wire logic                              I_REGULATOR_SHAPING_MODE,
  input  wire logic                              I_MODULATION_PAUSE,
  input  wire logic                              I_RECEIVE_PERIOD,
  // Wave shaping controls to the analog front end
  output logic                                   O_DRIVER_ON_RF_REGULATOR_SUPPLY,
  output logic                                   O_RF_REGULATOR_CONTINUOUS,
  output logic                                   O_FIELD_ONOFF_SHAPING,
  output logic                                   O_SHAPE_SYMMETRY_SELECT,
  output logic                                   O_STRONG_SINK,
  output logic [3:0]                             O_REFERENCE_FILTER_CONSTANT
);
  import wave_shaping_gain_pkg::*;

  bus_state_t bus_state;
  bus_state_t next_bus_state;
  logic [7:0] cfg_one;
  logic [7:0] next_cfg_one;
  logic [7:0] cfg_two;
  logic [7:0] next_cfg_two;
  apb_data_t  next_prdata;
  logic       next_pready;
  logic       next_pslverr;
  gain_cut_t  am_total_gain_cut;
  gain_cut_t  pm_total_gain_cut;
  logic       next_driver_rf;
  logic       next_cont;
  logic       next_onoff;
  logic       next_sym;
  logic       next_sink;
  logic [3:0] next_filt;
  logic       access;
  logic       hit_gain;
  logic       hit_one;
  logic       hit_two;

  // Byte address of a register index within a space
  function automatic apb_addr_t reg_addr(input apb_addr_t base, input logic [7:0] idx);
    reg_addr = base + {2'b00, idx, 2'b00};
  endfunction

  // AM and PM totals each get their own combiner
  gain_cut_combiner u_am_comb (
    .i_clk     (I_CLK),
    .i_reset_n (I_RESET_N),
    .i_setting (I_AM_GAIN_SETTING_FIELD),
    .i_squelch (I_AM_SQUELCH_CUT),
    .i_agc     (I_AM_AGC_CUT),
    .o_total   (am_total_gain_cut)
  );

  gain_cut_combiner u_pm_comb (
    .i_clk     (I_CLK),
    .i_reset_n (I_RESET_N),
    .i_setting (I_PM_GAIN_SETTING_FIELD),
    .i_squelch (I_PM_SQUELCH_CUT),
    .i_agc     (I_PM_AGC_CUT),
    .o_total   (pm_total_gain_cut)
  );

  // Address decode of the access phase
  assign access   = I_PSEL && I_PENABLE && (bus_state == BUS_IDLE);
  assign hit_gain = (I_PADDR == reg_addr(`SPACE_A_BASE, `IDX_GAIN_STATE));
  assign hit_one  = (I_PADDR == reg_addr(`SPACE_B_BASE, `IDX_WS_CONFIG_ONE));
  assign hit_two  = (I_PADDR == reg_addr(`SPACE_B_BASE, `IDX_WS_CONFIG_TWO));

  // Bus next state; one wait state so every bus output leaves a flip-flop
  always_comb begin
    next_bus_state = BUS_IDLE;
    next_pready    = 1'b0;
    next_pslverr   = 1'b0;
    next_prdata    = 32'h0000_0000;
    next_cfg_one   = cfg_one;
    next_cfg_two   = cfg_two;
    case (bus_state)
      BUS_IDLE: begin
        if (access) begin
          next_bus_state = BUS_ANSWER;
          next_pready    = 1'b1;
          next_pslverr   = !(hit_gain || hit_one || hit_two);
          if (I_PWRITE) begin
            // Reserved bits are dropped so they always read zero
            if (hit_one) begin
              next_cfg_one = I_PWDATA[7:0] & 8'h0B;
            end
            if (hit_two) begin
              next_cfg_two = I_PWDATA[7:0] & 8'h3F;
            end
          end else if (hit_gain) begin
            next_prdata = {24'h00_0000, am_total_gain_cut, pm_total_gain_cut};
          end else if (hit_one) begin
            next_prdata = {24'h00_0000, cfg_one};
          end else if (hit_two) begin
            next_prdata = {24'h00_0000, cfg_two};
          end
        end
      end
      BUS_ANSWER: begin
        next_bus_state = BUS_IDLE;
      end
      default: begin
        next_bus_state = BUS_IDLE;
      end
    endcase
  end

  // Wave shaping controls; all forced inactive unless shaping mode is on
  always_comb begin
    next_driver_rf = 1'b0;
    next_cont      = 1'b0;
    next_onoff     = 1'b0;
    next_sym       = 1'b0;
    next_sink      = 1'b0;
    next_filt      = 4'h0;
    if (I_REGULATOR_SHAPING_MODE) begin
      next_cont  = cfg_one[`CFG1_CONT_BIT];
      next_onoff = cfg_one[`CFG1_ONOFF_BIT];
      next_sym   = cfg_two[`CFG2_SYM_BIT];
      next_sink  = cfg_two[`CFG2_SINK_BIT];
      next_filt  = cfg_two[`CFG2_FILT_MSB:`CFG2_FILT_LSB];
      // The rx-only choice is only safe with the internal regulator bypassed
      if (cfg_one[`CFG1_RX_ONLY_BIT]) begin
        next_driver_rf = I_RECEIVE_PERIOD;
      end else begin
        next_driver_rf = !I_MODULATION_PAUSE;
      end
    end
  end

  // Register all state and outputs
  always_ff @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      bus_state                       <= BUS_IDLE;
      cfg_one                         <= `CFG1_RESET;
      cfg_two                         <= `CFG2_RESET;
      O_PRDATA                        <= 32'h0000_0000;
      O_PREADY                        <= 1'b0;
      O_PSLVERR                       <= 1'b0;
      O_DRIVER_ON_RF_REGULATOR_SUPPLY <= 1'b0;
      O_RF_REGULATOR_CONTINUOUS       <= 1'b0;
      O_FIELD_ONOFF_SHAPING           <= 1'b0;
      O_SHAPE_SYMMETRY_SELECT         <= 1'b0;
      O_STRONG_SINK                   <= 1'b0;
      O_REFERENCE_FILTER_CONSTANT     <= 4'h0;
    end else begin
      bus_state                       <= next_bus_state;
      cfg_one                         <= next_cfg_one;
      cfg_two                         <= next_cfg_two;
      O_PRDATA                        <= next_prdata;
      O_PREADY                        <= next_pready;
      O_PSLVERR                       <= next_pslverr;
      O_DRIVER_ON_RF_REGULATOR_SUPPLY <= next_driver_rf;
      O_RF_REGULATOR_CONTINUOUS       <= next_cont;
      O_FIELD_ONOFF_SHAPING           <= next_onoff;
      O_SHAPE_SYMMETRY_SELECT         <= next_sym;
      O_STRONG_SINK                   <= next_sink;
      O_REFERENCE_FILTER_CONSTANT     <= next_filt;
    end
  end
endmodule // wave_shaping_gain_regs
`default_nettype wire

//--- tb/wave_shaping_gain_regs_props.sv
// Port checks for the wave shaping and gain state register bank
`timescale 1ns/1ps
`default_nettype none
module wave_shaping_gain_regs_props import wave_shaping_gain_pkg::*; (
  // Clock, reset and APB
  input wire logic       I_CLK, I_RESET_N, I_PSEL, I_PENABLE, I_PWRITE, O_PREADY, O_PSLVERR,
  input wire apb_addr_t  I_PADDR,
  input wire apb_data_t  I_PWDATA, O_PRDATA,
  // Gain contributions
  input wire gain_cut_t  I_AM_GAIN_SETTING_FIELD, I_AM_SQUELCH_CUT, I_AM_AGC_CUT,
  input wire gain_cut_t  I_PM_GAIN_SETTING_FIELD, I_PM_SQUELCH_CUT, I_PM_AGC_CUT,
  // Timing, mode and controls
  input wire logic       I_REGULATOR_SHAPING_MODE, I_MODULATION_PAUSE, I_RECEIVE_PERIOD,
  input wire logic       O_DRIVER_ON_RF_REGULATOR_SUPPLY, O_RF_REGULATOR_CONTINUOUS, O_FIELD_ONOFF_SHAPING,
  input wire logic       O_SHAPE_SYMMETRY_SELECT, O_STRONG_SINK,
  input wire logic [3:0] O_REFERENCE_FILTER_CONSTANT
);
  // Saturated channel total; a plain 4-bit sum would wrap on strong squelch plus AGC
  function automatic logic [3:0] sat(input logic [3:0] a, b, c);
    return (6'(a) + 6'(b) + 6'(c) > 6'hF) ? 4'hF : a + b + c;
  endfunction
  // Helper views of the ports
  wire logic       md   = I_REGULATOR_SHAPING_MODE;
  wire logic       take = I_PSEL && I_PENABLE && !O_PREADY;
  wire logic [3:0] am_g = sat(I_AM_GAIN_SETTING_FIELD, I_AM_SQUELCH_CUT, I_AM_AGC_CUT);
  wire logic [3:0] pm_g = sat(I_PM_GAIN_SETTING_FIELD, I_PM_SQUELCH_CUT, I_PM_AGC_CUT);
  wire logic [1:0] w_one = {I_PWDATA[3], I_PWDATA[0]};
  wire logic [5:0] w_two = I_PWDATA[5:0];
  wire logic [8:0] outs = {O_DRIVER_ON_RF_REGULATOR_SUPPLY, O_RF_REGULATOR_CONTINUOUS, O_FIELD_ONOFF_SHAPING,
                           O_SHAPE_SYMMETRY_SELECT, O_STRONG_SINK, O_REFERENCE_FILTER_CONSTANT};
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);
  // Gain totals seen two edges before the answer; config lands one edge after the write
  sequence s_gain_rd; take && !I_PWRITE && I_PADDR == 12'h0B8; endsequence
  property p_am_gain; s_gain_rd |=> O_PRDATA[31:4] == {24'h0, $past(am_g, 2)}; endproperty
  a_am_gain: assert property (p_am_gain) else $error("am gain total wrong");
  property p_pm_gain; s_gain_rd |=> O_PRDATA[3:0] == $past(pm_g, 2); endproperty
  a_pm_gain: assert property (p_pm_gain) else $error("pm gain total wrong");
  property p_pause; md && I_MODULATION_PAUSE && !I_RECEIVE_PERIOD |=> !outs[8]; endproperty
  a_pause: assert property (p_pause) else $error("driver on supply in pause");
  property p_rx; md && !I_MODULATION_PAUSE && I_RECEIVE_PERIOD |=> outs[8]; endproperty
  a_rx: assert property (p_rx) else $error("driver off supply in receive");
  property p_one; take && I_PWRITE && I_PADDR == 12'h1B8 ##1 md |=> outs[7:6] == $past(w_one, 2); endproperty
  a_one: assert property (p_one) else $error("config one not applied");
  property p_two; take && I_PWRITE && I_PADDR == 12'h1BC ##1 md |=> outs[5:0] == $past(w_two, 2); endproperty
  a_two: assert property (p_two) else $error("config two not applied");
  property p_off; !md |=> outs == 9'h000; endproperty
  a_off: assert property (p_off) else $error("control active with shaping off");
  property p_ans; take |=> O_PREADY ##1 !O_PREADY; endproperty
  a_ans: assert property (p_ans) else $error("answer not a single cycle");
  // Main scenarios reached
  c_gain: cover property (s_gain_rd);
  c_err: cover property (O_PREADY && O_PSLVERR);
  c_rx: cover property (md && I_RECEIVE_PERIOD ##1 outs[8]);
endmodule // wave_shaping_gain_regs_props
bind wave_shaping_gain_regs wave_shaping_gain_regs_props i_props (.*);
`default_nettype wire

//--- tb/test_wave_shaping_gain_regs.sv
// Self-checking bench for the wave shaping and gain state register bank
`timescale 1ns/1ps
`default_nettype none
module test_wave_shaping_gain_regs;
  import wave_shaping_gain_pkg::*;
  // Stimulus, named as the ports so the instance connects by name
  logic      I_CLK = 0, I_RESET_N = 0, I_PSEL = 0, I_PENABLE = 0, I_PWRITE = 0;
  logic      I_REGULATOR_SHAPING_MODE = 0, I_MODULATION_PAUSE = 0, I_RECEIVE_PERIOD = 0;
  apb_addr_t I_PADDR = '0;
  apb_data_t I_PWDATA = '0;
  gain_cut_t I_AM_GAIN_SETTING_FIELD = '0, I_AM_SQUELCH_CUT = '0, I_AM_AGC_CUT = '0;
  gain_cut_t I_PM_GAIN_SETTING_FIELD = '0, I_PM_SQUELCH_CUT = '0, I_PM_AGC_CUT = '0;
  // Outputs
  apb_data_t  O_PRDATA;
  logic       O_PREADY, O_PSLVERR, O_DRIVER_ON_RF_REGULATOR_SUPPLY, O_RF_REGULATOR_CONTINUOUS;
  logic       O_FIELD_ONOFF_SHAPING, O_SHAPE_SYMMETRY_SELECT, O_STRONG_SINK;
  logic [3:0] O_REFERENCE_FILTER_CONSTANT;
  // Notes, register model and counters
  logic [33:0] exp_q[$];
  logic [33:0] got;
  logic [7:0]  cfg1 = 8'h00, cfg2 = 8'h00;
  int          bad_count = 0, num_checks = 0, cycles = 0;
  wire logic   md = I_REGULATOR_SHAPING_MODE;
  wire logic [8:0] outs = {O_DRIVER_ON_RF_REGULATOR_SUPPLY, O_RF_REGULATOR_CONTINUOUS, O_FIELD_ONOFF_SHAPING,
                           O_SHAPE_SYMMETRY_SELECT, O_STRONG_SINK, O_REFERENCE_FILTER_CONSTANT};

  wave_shaping_gain_regs i_wave_shaping_gain_regs (.*);

  // 20 MHz clock
  always #25 I_CLK = ~I_CLK;

  function automatic logic [3:0] sat(input logic [3:0] a, b, c);
    return (6'(a) + 6'(b) + 6'(c) > 6'hF) ? 4'hF : a + b + c;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h, expected %h", $time, seen, want);
    end
  endtask

  task automatic wrap_up;
    if (bad_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // One APB transfer; the note is queued first, and refused writes leave the model alone
  task automatic apb(input logic w, input apb_addr_t a, input apb_data_t d);
    logic [31:0] e;
    @(posedge I_CLK);
    e = a == 12'h0B8 ? {24'h0, sat(I_AM_GAIN_SETTING_FIELD, I_AM_SQUELCH_CUT, I_AM_AGC_CUT),
        sat(I_PM_GAIN_SETTING_FIELD, I_PM_SQUELCH_CUT, I_PM_AGC_CUT)} : a == 12'h1B8 ? cfg1 : a == 12'h1BC ? cfg2 : 0;
    exp_q.push_back({!w, !(a inside {12'h0B8, 12'h1B8, 12'h1BC}), e});
    if (w && a == 12'h1B8) cfg1 = d[7:0] & 8'h0B;
    if (w && a == 12'h1BC) cfg2 = d[7:0] & 8'h3F;
    I_PSEL <= 1;
    I_PENABLE <= 0;
    I_PWRITE <= w;
    I_PADDR <= a;
    I_PWDATA <= d;
    @(posedge I_CLK);
    I_PENABLE <= 1;
    do @(posedge I_CLK); while (O_PREADY !== 1'b1);
    I_PSEL <= 0;
    I_PENABLE <= 0;
  endtask

  // Controls settle two edges after a change
  task automatic ctl;
    repeat (2) @(posedge I_CLK);
    check(32'(outs[7:6]), md ? 32'({cfg1[3], cfg1[0]}) : 0);
    check(32'(outs[5:0]), md ? 32'(cfg2[5:0]) : 0);
    check(32'(outs[8]), 32'(md & (cfg1[1] ? I_RECEIVE_PERIOD : !I_MODULATION_PAUSE)));
  endtask

  // Each answer is matched against the oldest note
  always @(posedge I_CLK) begin
    if (O_PREADY === 1'b1) begin
      got = exp_q.pop_front();
      check(32'(O_PSLVERR), 32'(got[32]));
      if (got[33]) check(O_PRDATA, got[31:0]);
    end
  end

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge I_CLK) begin
    if (++cycles == 6000) begin
      bad_count++;
      wrap_up();
    end
  end

  initial begin
    void'($urandom(32'h81C10665));
    repeat (20) @(posedge I_CLK);
    I_RESET_N <= 1;
    apb(0, 12'h1B8, 0);
    apb(0, 12'h1BC, 0);
    ctl();
    // Random gains, mode and config, with refused and read-only accesses mixed in
    repeat (12) begin
      {I_AM_GAIN_SETTING_FIELD, I_AM_SQUELCH_CUT, I_AM_AGC_CUT, I_PM_GAIN_SETTING_FIELD, I_PM_SQUELCH_CUT,
       I_PM_AGC_CUT} <= 24'($urandom);
      I_REGULATOR_SHAPING_MODE <= 1'($urandom);
      apb(0, 12'h0B8, 0);
      apb(1, 12'h0B8, $urandom);
      apb(1, 12'h1B8, $urandom);
      apb(1, 12'h1BC, $urandom);
      apb(1'($urandom), 12'h200 | 12'($urandom & 'h1FC), $urandom);
      apb(0, 12'h0BC, 0);
      apb(0, 12'h1B8, 0);
      apb(0, 12'h1BC, 0);
      ctl();
    end
    // Supply choice over every select, pause and receive combination
    I_REGULATOR_SHAPING_MODE <= 1;
    // Symmetrical shape, as suits ASK modulation, with a filter constant of 5
    apb(1, 12'h1BC, 32'h25);
    // Rx-only select at 1 stands for a board with the internal regulator bypassed
    for (int i = 0; i < 8; i++) begin
      apb(1, 12'h1B8, 32'h9 | 32'(i[0]) << 1);
      I_MODULATION_PAUSE <= i[1];
      I_RECEIVE_PERIOD <= i[2];
      ctl();
    end
    wrap_up();
  end
endmodule // test_wave_shaping_gain_regs
`default_nettype wire
